/* File: pkg/prog_protect_pkg.sv */
// Package for the program memory protection block: layouts, levels, sizes.
// Assumes a single core clock and an active-low asynchronous reset.
package prog_protect_pkg;

  // Encryption array geometry
  localparam int unsigned KEY_DEPTH  = 64;           // Key bytes in the array
  localparam int unsigned KEY_AW     = 6;            // Key index width
  localparam int unsigned CODE_AW    = 16;           // Code address width
  localparam logic [7:0]  ERASED     = 8'hff;        // Erased byte value

  // Lock bit vector positions
  localparam int unsigned LB_ONE     = 0;
  localparam int unsigned LB_TWO     = 1;
  localparam int unsigned LB_THREE   = 2;

  // Decoded protection levels, Gray along the usual path
  typedef enum logic [1:0] {
    LVL_NONE   = 2'b00,
    LVL_BASIC  = 2'b01,
    LVL_NOVER  = 2'b11,
    LVL_NOEXEC = 2'b10
  } prot_level_e;

  // Restrictions derived from a level
  typedef struct packed {
    logic table_read_block;   // Block table reads from external code
    logic access_latched;     // External access held from reset
    logic prog_inhibit;       // Refuse programming
    logic verify_inhibit;     // Refuse verification
    logic ext_exec_block;     // Refuse external execution
  } restrict_s;

  // Verify request from programmer
  typedef struct packed {
    logic                 req;    // One-cycle request
    logic [CODE_AW-1:0]   addr;   // Code address
  } verify_req_s;

endpackage : prog_protect_pkg

/* File: design/lock_level_decode.sv */
// Decodes the three lock bits into a protection level and restrictions.
// Assumes lock bits are active high meaning programmed; purely combinational.
`timescale 1ns/1ps
module lock_level_decode (
  input  wire logic [2:0]                lock_bits,
  output prog_protect_pkg::prot_level_e  level,
  output prog_protect_pkg::restrict_s    restr
);
  wire lock_bit_one   = lock_bits[prog_protect_pkg::LB_ONE];    // First lock bit
  wire lock_bit_two   = lock_bits[prog_protect_pkg::LB_TWO];    // Second lock bit
  wire lock_bit_three = lock_bits[prog_protect_pkg::LB_THREE];  // Third lock bit

  // Undefined combinations fall to the strongest level implied so far
  assign level = !lock_bit_one   ? prog_protect_pkg::LVL_NONE :
                 !lock_bit_two   ? prog_protect_pkg::LVL_BASIC :
                 !lock_bit_three ? prog_protect_pkg::LVL_NOVER :
                                   prog_protect_pkg::LVL_NOEXEC;

  // Levels are cumulative
  assign restr.table_read_block = (level != prog_protect_pkg::LVL_NONE);
  assign restr.access_latched   = (level != prog_protect_pkg::LVL_NONE);
  assign restr.prog_inhibit     = (level != prog_protect_pkg::LVL_NONE);
  assign restr.verify_inhibit   = (level == prog_protect_pkg::LVL_NOVER) ||
                                  (level == prog_protect_pkg::LVL_NOEXEC);
  assign restr.ext_exec_block   = (level == prog_protect_pkg::LVL_NOEXEC);
endmodule : lock_level_decode

/* File: design/program_memory_protection.sv */
// Program memory protection: key-array verify scrambling and lock levels.
// Assumes code memory and key array reads are combinational from outside.
// Functional notes
// (R1) Verify output is code XNOR key byte
// (R2) Erased bytes read all ones; bypass
// (R3) Keys applied in fixed address sequence
// (R4) No lock bits: no restrictions
// (R5) Level two blocks external table reads
// (R6) Level two latches external access at reset
// (R7) Level two refuses programming
// (R8) Level three also disables verification
// (R9) Level four also blocks external execution
// (R10) Mask parts: key array forces lock one
// (R11) Programmer fills unused code with varied values
// (R12) Lock state captured at reset, held
`timescale 1ns/1ps
module program_memory_protection (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic [2:0]                            nv_lock_bits,
  input  wire logic                                  mask_variant,
  input  wire logic                                  key_array_supplied,
  input  wire logic                                  external_access_pin,
  input  wire prog_protect_pkg::verify_req_s         verify_req,
  input  wire logic [7:0]                            code_byte,
  input  wire logic [7:0]                            key_byte,
  input  wire logic                                  prog_req,
  input  wire logic                                  code_table_read_instruction,
  input  wire logic                                  fetch_from_external,
  input  wire logic                                  ext_fetch_req,
  output logic [prog_protect_pkg::CODE_AW-1:0]       code_addr,
  output logic [prog_protect_pkg::KEY_AW-1:0]        key_index,
  output logic [7:0]                                 verify_data,
  output logic                                       verify_valid,
  output logic                                       verify_refused,
  output logic                                       prog_grant,
  output logic                                       table_read_allow,
  output logic                                       ext_exec_allow,
  output logic                                       access_effective,
  output prog_protect_pkg::prot_level_e              level
);

  // Synchronised external access pin
  logic access_s1_q;
  logic access_s2_q;
  // Lock capture state
  logic                           captured_q;    // Capture done since reset
  logic [2:0]                     lock_q;        // Held lock bits
  logic                           access_hold_q; // Latched external access
  logic [2:0]                     lock_d;        // Lock bits to capture
  prog_protect_pkg::restrict_s    restr;         // Decoded restrictions

  // Pin synchroniser, free-running through reset so the pin is
  // already settled in the second stage when reset lifts
  always_ff @(posedge clk) begin
    access_s1_q <= external_access_pin;
    access_s2_q <= access_s1_q;
  end

  // Mask variants with a supplied key array carry lock one
  assign lock_d = nv_lock_bits |
                  {2'b00, mask_variant & key_array_supplied}; // R10

  // Capture lock bits and external access once after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_q <= 1'b0;
      lock_q     <= 3'b111;   // Safest until captured
      access_hold_q <= 1'b0;
    end else if (!captured_q) begin
      captured_q    <= 1'b1;
      lock_q        <= lock_d;       // R12
      access_hold_q <= access_s2_q;  // R6
    end
  end

  // Level decoder
  lock_level_decode u_decode (
    .lock_bits (lock_q),
    .level     (level),
    .restr     (restr)
  );

  // External access: latched copy under lock, else live pin
  assign access_effective = restr.access_latched ? access_hold_q : access_s2_q; // R6 R4

  // Table read gating
  assign table_read_allow = captured_q &&
    !(restr.table_read_block && code_table_read_instruction
      && fetch_from_external); // R5

  // Programming gate
  assign prog_grant = captured_q && prog_req && !restr.prog_inhibit; // R7

  // External execution gate
  assign ext_exec_allow = captured_q && ext_fetch_req && !restr.ext_exec_block; // R9

  // Address and key index sequencing, key follows low address bits
  assign code_addr = verify_req.addr;
  assign key_index = verify_req.addr[prog_protect_pkg::KEY_AW-1:0]; // R3

  // Verify answer register, one cycle after request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      verify_data    <= prog_protect_pkg::ERASED;
      verify_valid   <= 1'b0;
      verify_refused <= 1'b0;
    end else begin
      verify_valid   <= verify_req.req && captured_q && !restr.verify_inhibit; // R8
      verify_refused <= verify_req.req && (!captured_q || restr.verify_inhibit);
      if (verify_req.req && captured_q && !restr.verify_inhibit) begin
        verify_data <= ~(code_byte ^ key_byte); // R1 R2
      end
    end
  end

  // Verify returns scrambled byte one cycle after an accepted request
  property p_verify_xnor;
    @(posedge clk) disable iff (!rst_n)
      (verify_req.req && captured_q && !restr.verify_inhibit)
      |=> verify_valid && (verify_data == ~($past(code_byte) ^ $past(key_byte)));
  endproperty
  a_verify_xnor: assert property (p_verify_xnor) else $error("verify data wrong"); // R1

  // Erased key leaves code unchanged
  property p_erased_key;
    @(posedge clk) disable iff (!rst_n)
      (verify_valid && $past(key_byte) == prog_protect_pkg::ERASED)
      |-> verify_data == $past(code_byte);
  endproperty
  a_erased_key: assert property (p_erased_key) else $error("erased key altered byte"); // R2

  // Key index tracks address
  property p_key_seq;
    @(posedge clk) disable iff (!rst_n)
      key_index == code_addr[prog_protect_pkg::KEY_AW-1:0];
  endproperty
  a_key_seq: assert property (p_key_seq) else $error("key index out of sequence"); // R3

  // No lock bits means the programming, table read and external access gates pass
  property p_unlocked;
    @(posedge clk) disable iff (!rst_n)
      (captured_q && lock_q == 3'b000) |->
        (prog_grant == prog_req) && table_read_allow && (access_effective == access_s2_q);
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("unlocked part restricted"); // R4

  // Locked part blocks external table reads
  property p_table_block;
    @(posedge clk) disable iff (!rst_n)
      (lock_q[prog_protect_pkg::LB_ONE] && code_table_read_instruction
       && fetch_from_external) |-> !table_read_allow;
  endproperty
  a_table_block: assert property (p_table_block) else $error("table read leaked"); // R5

  // Latched external access holds after capture
  property p_access_hold;
    @(posedge clk) disable iff (!rst_n)
      (captured_q && $past(captured_q) && lock_q[prog_protect_pkg::LB_ONE])
      |-> $stable(access_effective);
  endproperty
  a_access_hold: assert property (p_access_hold) else $error("external access not held"); // R6

  // Locked part refuses programming
  property p_prog_block;
    @(posedge clk) disable iff (!rst_n)
      lock_q[prog_protect_pkg::LB_ONE] |-> !prog_grant;
  endproperty
  a_prog_block: assert property (p_prog_block) else $error("programming granted"); // R7

  // Level three refuses verify
  property p_verify_block;
    @(posedge clk) disable iff (!rst_n)
      (verify_req.req && lock_q[1:0] == 2'b11) |=> verify_refused && !verify_valid;
  endproperty
  a_verify_block: assert property (p_verify_block) else $error("verify not refused"); // R8

  // Level four blocks external execution
  property p_exec_block;
    @(posedge clk) disable iff (!rst_n)
      (lock_q == 3'b111) |-> !ext_exec_allow;
  endproperty
  a_exec_block: assert property (p_exec_block) else $error("external execution allowed"); // R9

  // Lock state constant once captured
  property p_lock_stable;
    @(posedge clk) disable iff (!rst_n)
      (captured_q && $past(captured_q)) |-> $stable(lock_q) && $stable(level);
  endproperty
  a_lock_stable: assert property (p_lock_stable) else $error("lock state changed"); // R12

endmodule : program_memory_protection

/* File: verification/code_store_model.sv */
// Far-side model: code memory and encryption key array, read combinationally.
// Assumes the block drives code_addr and key_index; erased bytes read ff.
`timescale 1ns/1ps
module code_store_model (
  input  wire logic [prog_protect_pkg::CODE_AW-1:0] code_addr,
  input  wire logic [prog_protect_pkg::KEY_AW-1:0]  key_index,
  input  wire logic                                 keys_programmed,
  output logic [7:0]                                code_byte,
  output logic [7:0]                                key_byte
);
  // Unused code filled with values varied by address, ff possible
  assign code_byte = code_addr[7:0] ^ code_addr[15:8] ^ 8'h5a;
  // Key array erased to ff until programmed
  assign key_byte = keys_programmed ? {key_index, 2'b01} : prog_protect_pkg::ERASED;
endmodule : code_store_model

/* File: verification/test_program_memory_protection.sv */
// Testbench for the program memory protection block.
// Assumes the block sits between the code store model and a bench-driven core.
`timescale 1ns/1ps
module test_program_memory_protection;
  logic        clk = 0, rst_n = 0, mask = 0, supplied = 0, access_pin = 0, keys_on = 0;
  logic [2:0]  lock = 3'h0;                          // Lock bits, 1 = programmed
  logic        prog_req = 0, tbl = 0, fext = 0, xreq = 0;
  prog_protect_pkg::verify_req_s vreq = '0;          // Verify request
  logic [15:0] code_addr;
  logic [5:0]  key_index;
  logic [7:0]  code_byte, key_byte, verify_data;
  logic        verify_valid, verify_refused, prog_grant, table_read_allow;
  logic        ext_exec_allow, access_effective;
  prog_protect_pkg::prot_level_e level;
  int          fail_count = 0, tests_run = 0;
  logic [2:0]  lbs [4] = '{3'h0, 3'h1, 3'h3, 3'h7}; // Defined lock combos
  logic [1:0]  lvs [4] = '{2'h0, 2'h1, 2'h3, 2'h2}; // Their levels
  // Clock 40 MHz
  always #12.5 clk = ~clk;
  program_memory_protection dut (.clk(clk), .rst_n(rst_n), .nv_lock_bits(lock),
    .mask_variant(mask), .key_array_supplied(supplied), .external_access_pin(access_pin),
    .verify_req(vreq), .code_byte(code_byte), .key_byte(key_byte), .prog_req(prog_req),
    .code_table_read_instruction(tbl), .fetch_from_external(fext), .ext_fetch_req(xreq),
    .code_addr(code_addr), .key_index(key_index), .verify_data(verify_data),
    .verify_valid(verify_valid), .verify_refused(verify_refused), .prog_grant(prog_grant),
    .table_read_allow(table_read_allow), .ext_exec_allow(ext_exec_allow),
    .access_effective(access_effective), .level(level));
  code_store_model store (.code_addr(code_addr), .key_index(key_index),
    .keys_programmed(keys_on), .code_byte(code_byte), .key_byte(key_byte));
  // Compare one value
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk
  // Reset with given lock bits and pin level, then wait for capture
  task boot(input logic [2:0] lb, input logic pin);
    @(posedge clk);
    rst_n <= 0;
    lock  <= lb;
    access_pin <= pin;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
  endtask : boot
  // One verify access; checks the answer cycle
  task verify(input logic [15:0] a, input logic ok, input logic [7:0] exp);
    @(posedge clk);
    vreq <= '{req: 1'b1, addr: a};
    @(posedge clk);
    vreq <= '0;
    #1;
    chk("verify_valid", {7'h0, ok}, {7'h0, verify_valid});
    chk("verify_refused", {7'h0, !ok}, {7'h0, verify_refused});
    if (ok) chk("verify_data", exp, verify_data);
  endtask : verify
  // Verdict
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(lbs[i], 1'b1);
      access_pin <= 0;
      prog_req <= 1;
      tbl <= 1;
      fext <= 1;
      xreq <= 1;
      repeat (4) @(posedge clk);
      #1;
      chk("level", {6'h0, lvs[i]}, {6'h0, level});
      chk("prog_grant", {7'h0, !lbs[i][0]}, {7'h0, prog_grant});
      chk("table_read", {7'h0, !lbs[i][0]}, {7'h0, table_read_allow});
      chk("ext_exec", {7'h0, !lbs[i][2]}, {7'h0, ext_exec_allow});
      chk("access_effective", {7'h0, lbs[i][0]}, {7'h0, access_effective});
      verify(16'h0047, !lbs[i][1], 8'h47 ^ 8'h5a);
    end
    boot(3'h0, 1'b0);
    keys_on <= 1;
    verify(16'h0047, 1'b1, ~((8'h47 ^ 8'h5a) ^ 8'h1d));
    verify(16'h0308, 1'b1, ~((8'h0b ^ 8'h5a) ^ 8'h21));
    @(posedge clk);
    mask <= 1;
    supplied <= 1;
    boot(3'h0, 1'b0);
    #1;
    chk("mask_level", 8'h01, {6'h0, level});
    chk("mask_prog", 8'h00, {7'h0, prog_grant});
    // Lock inputs and pin move after capture; level and latch must hold
    @(posedge clk);
    lock <= 3'h7;
    access_pin <= 1;
    repeat (3) @(posedge clk);
    #1;
    chk("held_level", 8'h01, {6'h0, level});
    chk("held_access", 8'h00, {7'h0, access_effective});
    wrap_up();
  end
endmodule : test_program_memory_protection
